// File: design/comm_angle_pkg.sv
// Constants for the commutation angle select and offset adjust block
`default_nettype none
package comm_angle_pkg;
   // Register byte offsets
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_OFFSET = 8'h04;
   localparam logic [7:0] ADDR_GAIN   = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0C;
   localparam logic [7:0] ADDR_ANGLE  = 8'h10;
   // CTRL fields
   localparam int CTRL_SRC_LSB   = 0;
   localparam int CTRL_TORQUE    = 2;
   localparam int CTRL_SW_EN     = 3;
   localparam int CTRL_START     = 4;
   // GAIN fields
   localparam int GAIN_KI_LSB    = 16;
   // STATUS fields
   localparam int STAT_DONE      = 0;
   localparam int STAT_ARMED     = 1;
   localparam int STAT_DRIVE_EN  = 2;
   localparam int STAT_STATE_LSB = 3;
   // Angle sources
   localparam logic [1:0] SRC_ZERO     = 2'h0;
   localparam logic [1:0] SRC_RESOLVER = 2'h1;
   localparam logic [1:0] SRC_ENCODER  = 2'h2;
   // Reset values
   localparam logic [1:0]  RST_SRC    = 2'h0;
   localparam logic [15:0] RST_OFFSET = 16'h0000;
   localparam logic [15:0] RST_KP     = 16'h0000;
   localparam logic [15:0] RST_KI     = 16'h0000;
   // Adjust sequence figures
   localparam logic [15:0] TORQUE_MAX   = 16'h7FFF;
   localparam int          FREE_SHIFT   = 3;
   localparam int          ALIGN_SHIFT  = 2;
   localparam int          GAIN_SHIFT   = 1;
   localparam logic [15:0] FREE_ANGLE   = 16'h4000;
   localparam logic [15:0] ALIGN_ANGLE  = 16'h0000;
   // Timing
   localparam int CLK_HZ        = 50000000;
   localparam int FREE_TIME_MS  = 1000;
   localparam int ALIGN_TIME_MS = 2000;
   localparam int FREE_CYCLES   = FREE_TIME_MS * (CLK_HZ / 1000);
   localparam int ALIGN_CYCLES  = ALIGN_TIME_MS * (CLK_HZ / 1000);
   localparam int CNT_W         = 27;
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_ARMED = 3'b001,
      ST_FREE  = 3'b010,
      ST_ALIGN = 3'b011
   } adj_state_e;
endpackage : comm_angle_pkg
`default_nettype wire

// File: design/angle_select.sv
// Commutation angle source mux with offset addition
`default_nettype none
module angle_select (
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic        ce,
   input  wire logic [1:0]  src,
   input  wire logic [15:0] resolver_pos,
   input  wire logic [15:0] encoder_angle,
   input  wire logic [15:0] offset,
   input  wire logic        force_en,
   input  wire logic [15:0] force_angle,
   output logic      [15:0] raw_angle,
   output logic      [15:0] comm_angle
);
   typedef struct packed {
      logic [15:0] raw;
      logic [15:0] comm;
   } sel_s;

   sel_s cur_r;
   sel_s cur_nxt;

   always_comb begin
      cur_nxt = cur_r;
      unique case (src)
         comm_angle_pkg::SRC_RESOLVER: cur_nxt.raw = resolver_pos;
         comm_angle_pkg::SRC_ENCODER:  cur_nxt.raw = encoder_angle;
         default:                      cur_nxt.raw = 16'h0000;
      endcase
      if (force_en) begin
         cur_nxt.comm = force_angle;
      end else begin
         cur_nxt.comm = cur_nxt.raw + offset;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cur_r <= '0;
      end else if (ce) begin
         cur_r <= cur_nxt;
      end
   end

   assign raw_angle  = cur_r.raw;
   assign comm_angle = cur_r.comm;
endmodule : angle_select
`default_nettype wire

// File: design/comm_angle_adjust.sv
// Commutation angle select, offset register and automatic offset adjust
//
// Overview of operation
// - Fixed source forces feedback angle zero
// - Resolver source: 16-bit per mechanical revolution
// - Encoder source: 16-bit per mechanical revolution
// - Offset added between feedback and current angle
// - Adjust start halves current loop gains
// - First command one eighth torque to free
// - Then quarter torque at angle, derive offset
// - Sequence begins on enable after arming
// - Done indicator returns zero on completion
// - Enabled needs hardware and software enable
//
// Implementation choices: the register addresses and the APB register port.
`default_nettype none
module comm_angle_adjust #(
   parameter int FREE_CYCLES  = comm_angle_pkg::FREE_CYCLES,
   parameter int ALIGN_CYCLES = comm_angle_pkg::ALIGN_CYCLES
) (
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic        ce,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        hw_enable,
   input  wire logic [15:0] resolver_pos,
   input  wire logic [15:0] encoder_angle,
   output logic      [15:0] comm_angle,
   output logic      [15:0] torque_cmd,
   output logic      [15:0] kp_gain,
   output logic      [15:0] ki_gain,
   output logic             drive_en,
   output logic             torque_mode
);
   localparam int CW = comm_angle_pkg::CNT_W;

   if (FREE_CYCLES < 1 || ALIGN_CYCLES < 1 || FREE_CYCLES >= (2 ** CW) || ALIGN_CYCLES >= (2 ** CW)) begin : g_bad_cycles
      $error("comm_angle_adjust: cycle counts out of range");
   end

   typedef struct packed {
      comm_angle_pkg::adj_state_e st;
      logic [CW-1:0] cnt;
      logic          hw_s1;
      logic          hw_s2;
      logic          en_prev;
      logic          done;
      logic [1:0]    src;
      logic          tq_mode;
      logic          sw_en;
      logic [15:0]   offset;
      logic [15:0]   kp;
      logic [15:0]   ki;
      logic [31:0]   rdata;
      logic          ready;
      logic          slverr;
      logic [15:0]   torque;
      logic [15:0]   kp_o;
      logic [15:0]   ki_o;
      logic          drv_en;
      logic          force_en;
      logic [15:0]   force_ang;
   } adj_s;

   adj_s cur_r;
   adj_s cur_nxt;

   logic [15:0] raw_angle;
   logic [15:0] angle_out;

   angle_select u_sel (
      .ref_clk       (ref_clk),
      .rst           (rst),
      .ce            (ce),
      .src           (cur_r.src),
      .resolver_pos  (resolver_pos),
      .encoder_angle (encoder_angle),
      .offset        (cur_r.offset),
      .force_en      (cur_r.force_en),
      .force_angle   (cur_r.force_ang),
      .raw_angle     (raw_angle),
      .comm_angle    (angle_out)
   );

   function automatic logic addr_known(input logic [7:0] a);
      addr_known = (a == comm_angle_pkg::ADDR_CTRL) || (a == comm_angle_pkg::ADDR_OFFSET) ||
                   (a == comm_angle_pkg::ADDR_GAIN) || (a == comm_angle_pkg::ADDR_STATUS) ||
                   (a == comm_angle_pkg::ADDR_ANGLE);
   endfunction : addr_known

   function automatic logic [31:0] read_word(input logic [7:0] a, input adj_s s, input logic [15:0] ang);
      read_word = 32'h0000_0000;
      unique case (a)
         comm_angle_pkg::ADDR_CTRL: begin
            read_word[comm_angle_pkg::CTRL_SRC_LSB +: 2] = s.src;
            read_word[comm_angle_pkg::CTRL_TORQUE]       = s.tq_mode;
            read_word[comm_angle_pkg::CTRL_SW_EN]        = s.sw_en;
         end
         comm_angle_pkg::ADDR_OFFSET: read_word[15:0] = s.offset;
         comm_angle_pkg::ADDR_GAIN:   read_word = {s.ki, s.kp};
         comm_angle_pkg::ADDR_STATUS: begin
            read_word[comm_angle_pkg::STAT_DONE]           = s.done;
            read_word[comm_angle_pkg::STAT_ARMED]          = (s.st == comm_angle_pkg::ST_ARMED);
            read_word[comm_angle_pkg::STAT_DRIVE_EN]       = s.drv_en;
            read_word[comm_angle_pkg::STAT_STATE_LSB +: 3] = s.st;
         end
         comm_angle_pkg::ADDR_ANGLE:  read_word[15:0] = ang;
         default:                     read_word = 32'h0000_0000;
      endcase
   endfunction : read_word

   logic        acc;
   logic        wr_ok;
   logic        en_now;
   logic        adjusting;

   always_comb begin
      cur_nxt     = cur_r;
      acc         = psel && penable;
      wr_ok       = acc && cur_r.ready && pwrite && addr_known(paddr);
      cur_nxt.hw_s1 = hw_enable;
      cur_nxt.hw_s2 = cur_r.hw_s1;
      // APB: one wait state, answer registered
      cur_nxt.ready  = acc && !cur_r.ready;
      cur_nxt.slverr = acc && !cur_r.ready && !addr_known(paddr);
      if (acc && !cur_r.ready && !pwrite) begin
         cur_nxt.rdata = read_word(paddr, cur_r, angle_out);
      end
      if (wr_ok) begin
         unique case (paddr)
            comm_angle_pkg::ADDR_CTRL: begin
               cur_nxt.src     = pwdata[comm_angle_pkg::CTRL_SRC_LSB +: 2];
               cur_nxt.tq_mode = pwdata[comm_angle_pkg::CTRL_TORQUE];
               cur_nxt.sw_en   = pwdata[comm_angle_pkg::CTRL_SW_EN];
            end
            comm_angle_pkg::ADDR_OFFSET: cur_nxt.offset = pwdata[15:0];
            comm_angle_pkg::ADDR_GAIN: begin
               cur_nxt.kp = pwdata[15:0];
               cur_nxt.ki = pwdata[comm_angle_pkg::GAIN_KI_LSB +: 16];
            end
            default: ;
         endcase
      end
      en_now          = cur_r.hw_s2 && cur_r.sw_en;
      cur_nxt.drv_en  = en_now;
      cur_nxt.en_prev = en_now;
      unique case (cur_r.st)
         comm_angle_pkg::ST_IDLE: begin
            if (wr_ok && paddr == comm_angle_pkg::ADDR_CTRL && pwdata[comm_angle_pkg::CTRL_START]) begin
               cur_nxt.st   = comm_angle_pkg::ST_ARMED;
               cur_nxt.done = 1'b1;
            end
         end
         comm_angle_pkg::ST_ARMED: begin
            if (en_now && !cur_r.en_prev) begin
               cur_nxt.st  = comm_angle_pkg::ST_FREE;
               cur_nxt.cnt = CW'(FREE_CYCLES - 1);
            end
         end
         comm_angle_pkg::ST_FREE: begin
            if (!en_now) begin
               cur_nxt.st   = comm_angle_pkg::ST_IDLE;
               cur_nxt.done = 1'b0;
            end else if (cur_r.cnt == '0) begin
               cur_nxt.st  = comm_angle_pkg::ST_ALIGN;
               cur_nxt.cnt = CW'(ALIGN_CYCLES - 1);
            end else begin
               cur_nxt.cnt = cur_r.cnt - CW'(1);
            end
         end
         comm_angle_pkg::ST_ALIGN: begin
            if (!en_now) begin
               cur_nxt.st   = comm_angle_pkg::ST_IDLE;
               cur_nxt.done = 1'b0;
            end else if (cur_r.cnt == '0) begin
               cur_nxt.st     = comm_angle_pkg::ST_IDLE;
               cur_nxt.done   = 1'b0;
               cur_nxt.offset = comm_angle_pkg::ALIGN_ANGLE - raw_angle;
            end else begin
               cur_nxt.cnt = cur_r.cnt - CW'(1);
            end
         end
         default: begin
            cur_nxt.st   = comm_angle_pkg::ST_IDLE;
            cur_nxt.done = 1'b0;
         end
      endcase
      adjusting = (cur_nxt.st == comm_angle_pkg::ST_FREE) || (cur_nxt.st == comm_angle_pkg::ST_ALIGN);
      if (adjusting) begin
         cur_nxt.kp_o = cur_nxt.kp >> comm_angle_pkg::GAIN_SHIFT;
         cur_nxt.ki_o = cur_nxt.ki >> comm_angle_pkg::GAIN_SHIFT;
      end else begin
         cur_nxt.kp_o = cur_nxt.kp;
         cur_nxt.ki_o = cur_nxt.ki;
      end
      cur_nxt.force_en = adjusting;
      if (cur_nxt.st == comm_angle_pkg::ST_FREE) begin
         cur_nxt.torque    = comm_angle_pkg::TORQUE_MAX >> comm_angle_pkg::FREE_SHIFT;
         cur_nxt.force_ang = comm_angle_pkg::FREE_ANGLE;
      end else if (cur_nxt.st == comm_angle_pkg::ST_ALIGN) begin
         cur_nxt.torque    = comm_angle_pkg::TORQUE_MAX >> comm_angle_pkg::ALIGN_SHIFT;
         cur_nxt.force_ang = comm_angle_pkg::ALIGN_ANGLE;
      end else begin
         cur_nxt.torque    = 16'h0000;
         cur_nxt.force_ang = 16'h0000;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cur_r        <= '0;
         cur_r.st     <= comm_angle_pkg::ST_IDLE;
         cur_r.src    <= comm_angle_pkg::RST_SRC;
         cur_r.offset <= comm_angle_pkg::RST_OFFSET;
         cur_r.kp     <= comm_angle_pkg::RST_KP;
         cur_r.ki     <= comm_angle_pkg::RST_KI;
         cur_r.kp_o   <= comm_angle_pkg::RST_KP;
         cur_r.ki_o   <= comm_angle_pkg::RST_KI;
      end else if (ce) begin
         cur_r <= cur_nxt;
      end
   end

   assign prdata      = cur_r.rdata;
   assign pready      = cur_r.ready;
   assign pslverr     = cur_r.slverr;
   assign comm_angle  = angle_out;
   assign torque_cmd  = cur_r.torque;
   assign kp_gain     = cur_r.kp_o;
   assign ki_gain     = cur_r.ki_o;
   assign drive_en    = cur_r.drv_en;
   assign torque_mode = cur_r.tq_mode;
endmodule : comm_angle_adjust
`default_nettype wire

// File: bench/comm_angle_props.sv
// Port checker for the commutation angle block
`default_nettype none
module comm_angle_props #(
   parameter int FREE_CYCLES  = 8,
   parameter int ALIGN_CYCLES = 16
) (
   input wire logic        ref_clk,
   input wire logic        rst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        hw_enable,
   input wire logic [15:0] torque_cmd,
   input wire logic [15:0] kp_gain,
   input wire logic        drive_en
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] prev_r;
   logic [31:0] run_r;
   logic [15:0] kp_save_r;
   // Run length of the torque level and gain seen while idle
   always_ff @(posedge ref_clk) begin
      prev_r <= torque_cmd;
      run_r <= rst ? 32'h0 : ((torque_cmd == prev_r) ? run_r + 32'h1 : 32'h1);
      if (torque_cmd == 16'h0000) kp_save_r <= kp_gain;
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   AST_READY_PULSE: assert property (pready |=> !pready) else $error("ready too long");
   AST_READY_CAUSE: assert property (pready |-> $past(psel) && $past(penable)) else $error("ready unasked");
   AST_ERR_READY: assert property (pslverr |-> pready) else $error("error without ready");
   AST_TORQUE_SET: assert property (torque_cmd inside {16'h0000, 16'h0FFF, 16'h1FFF}) else $error("torque");
   AST_HALF_GAIN: assert property ($rose(torque_cmd == 16'h0FFF) |-> kp_gain == kp_save_r >> 1) else $error("gain");
   AST_FREE_LEN: assert property (torque_cmd == 16'h1FFF && prev_r != 16'h1FFF
      |-> prev_r == 16'h0FFF && run_r == 32'(FREE_CYCLES)) else $error("free step");
   AST_ALIGN_END: assert property (torque_cmd == 16'h0000 && prev_r == 16'h1FFF
      |-> run_r == 32'(ALIGN_CYCLES) && kp_gain == kp_save_r) else $error("align end");
   AST_RUN_ENABLED: assert property (torque_cmd != 16'h0000 |-> drive_en) else $error("torque off");
   AST_DRIVE_PIN: assert property (drive_en |-> $past(hw_enable, 3)) else $error("drive enable");
   cover property ($rose(torque_cmd == 16'h0FFF));
   cover property (torque_cmd == 16'h0000 && prev_r == 16'h1FFF);
   cover property (pslverr);
endmodule : comm_angle_props
bind comm_angle_adjust comm_angle_props #(.FREE_CYCLES(FREE_CYCLES), .ALIGN_CYCLES(ALIGN_CYCLES)) i_props (
   .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
   .hw_enable(hw_enable), .torque_cmd(torque_cmd), .kp_gain(kp_gain), .drive_en(drive_en));
`default_nettype wire

// File: bench/fb_sensor_model.sv
// Resolver and encoder model of one rotor
`default_nettype none
module fb_sensor_model (
   input  wire logic        ref_clk,
   input  wire logic [15:0] rotor,
   output logic      [15:0] resolver_pos,
   output logic      [15:0] encoder_angle
);
   timeunit 1ns;
   timeprecision 1ns;
   always_ff @(posedge ref_clk) begin
      resolver_pos  <= rotor;
      encoder_angle <= rotor + 16'h2000;
   end
endmodule : fb_sensor_model
`default_nettype wire

// File: bench/comm_angle_adjust_tb_top.sv
// Testbench for the commutation angle block
`default_nettype none
module comm_angle_adjust_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic        ref_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, hw_enable = 1'b0, ce = 1'b1;
   logic        pready, pslverr, drive_en, torque_mode, err;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd, r, g, seed = 32'h00012239;
   logic [15:0] rotor = 16'h0, res_pos, enc_ang, comm_angle, torque_cmd, kp_gain, ki_gain;
   int          mismatches = 0, checks = 0;
   comm_angle_adjust #(.FREE_CYCLES(8), .ALIGN_CYCLES(16)) i_dut (.ref_clk(ref_clk), .rst(rst), .ce(ce),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .hw_enable(hw_enable), .resolver_pos(res_pos),
      .encoder_angle(enc_ang), .comm_angle(comm_angle), .torque_cmd(torque_cmd), .kp_gain(kp_gain),
      .ki_gain(ki_gain), .drive_en(drive_en), .torque_mode(torque_mode));
   fb_sensor_model i_fb (.ref_clk(ref_clk), .rotor(rotor), .resolver_pos(res_pos), .encoder_angle(enc_ang));
   initial forever #10 ref_clk = ~ref_clk;
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   function automatic logic [31:0] model(int s, int a, int o);
      int v;
      v = (s == 1) ? a : (s == 2) ? a + 'h2000 : 0;
      return (v + o) & 'hFFFF;
   endfunction : model
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wait_torque(input logic [15:0] v);
      int n;
      n = 0;
      while (torque_cmd !== v && n < 500) begin
         @(negedge ref_clk);
         n++;
      end
      check("torque", {16'h0, torque_cmd}, {16'h0, v});
   endtask : wait_torque
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : complete_run
   initial begin
      repeat (16) @(posedge ref_clk);
      rst <= 1'b0;
      for (int i = 0; i < 6; i++) begin
         apb(8'(i * 4), 1'b0, 32'h0);
         check("reset value", rd, 32'h0);
         check("slave error", {31'h0, err}, {31'h0, i == 5});
      end
      for (int i = 0; i < 8; i++) begin
         r = xs();
         rotor <= r[15:0];
         apb(comm_angle_pkg::ADDR_OFFSET, 1'b1, {16'h0, r[31:16]});
         apb(comm_angle_pkg::ADDR_CTRL, 1'b1, 32'(i % 4));
         apb(comm_angle_pkg::ADDR_ANGLE, 1'b0, 32'h0);
         check("angle", rd, model(i % 4, r[15:0], r[31:16]));
      end
      g = xs();
      apb(comm_angle_pkg::ADDR_GAIN, 1'b1, g);
      @(negedge ref_clk);
      check("gains", {ki_gain, kp_gain}, g);
      apb(comm_angle_pkg::ADDR_CTRL, 1'b1, 32'h15);
      apb(comm_angle_pkg::ADDR_STATUS, 1'b0, 32'h0);
      check("armed", rd, 32'h0B);
      rotor <= rotor + 16'h1234;
      ce <= 1'b0;
      repeat (4) @(posedge ref_clk);
      check("frozen angle", {16'h0, comm_angle}, model(1, r[15:0], r[31:16]));
      ce <= 1'b1;
      repeat (2) @(posedge ref_clk);
      check("thawed angle", {16'h0, comm_angle}, model(1, rotor, r[31:16]));
      hw_enable <= 1'b1;
      repeat (5) @(posedge ref_clk);
      check("half enable", {31'h0, drive_en}, 32'h0);
      check("torque mode", {31'h0, torque_mode}, 32'h1);
      apb(comm_angle_pkg::ADDR_CTRL, 1'b1, 32'h0D);
      wait_torque(16'h0FFF);
      @(negedge ref_clk);
      check("free angle", {16'h0, comm_angle}, {16'h0, comm_angle_pkg::FREE_ANGLE});
      check("free gain", {16'h0, kp_gain}, {17'h0, g[15:1]});
      wait_torque(16'h1FFF);
      @(negedge ref_clk);
      check("align angle", {16'h0, comm_angle}, {16'h0, comm_angle_pkg::ALIGN_ANGLE});
      check("align gain", {16'h0, ki_gain}, {17'h0, g[31:17]});
      wait_torque(16'h0000);
      check("gain back", {ki_gain, kp_gain}, g);
      apb(comm_angle_pkg::ADDR_STATUS, 1'b0, 32'h0);
      check("done", rd, 32'h04);
      apb(comm_angle_pkg::ADDR_OFFSET, 1'b0, 32'h0);
      check("offset", rd, {16'h0, 16'h0 - rotor});
      apb(comm_angle_pkg::ADDR_CTRL, 1'b1, 32'h1D);
      repeat (30) @(posedge ref_clk);
      check("no start", {16'h0, torque_cmd}, 32'h0);
      hw_enable <= 1'b0;
      repeat (6) @(posedge ref_clk);
      hw_enable <= 1'b1;
      wait_torque(16'h0FFF);
      check("restart", {16'h0, torque_cmd}, 32'h0FFF);
      @(posedge ref_clk);
      hw_enable <= 1'b0;
      wait_torque(16'h0000);
      apb(comm_angle_pkg::ADDR_STATUS, 1'b0, 32'h0);
      check("abort", rd, 32'h0);
      complete_run();
   end
   initial begin
      repeat (20000) @(posedge ref_clk);
      mismatches++;
      complete_run();
   end
endmodule : comm_angle_adjust_tb_top
`default_nettype wire
